// ==== msd_defs.svh ====
// constants for the microprogram store decode block
`ifndef MSD_DEFS_SVH
`define MSD_DEFS_SVH
// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define MSD_CTRL_OFS 4'h0
`define MSD_LADDR_OFS 4'h4
`define MSD_LDATA_OFS 4'h8
`define MSD_STAT_OFS 4'hc
// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define MSD_CTRL_UEN 0
`define MSD_CTRL_DEN 1
`define MSD_CTRL_RST 2'h3
`define MSD_LADDR_DSEL 15
`define MSD_STAT_DW_LSB 16
`define MSD_BUS_AW 4
// ---------------------------------------------------------------
// decode row codes, instruction bits 0:3 with bit 0 first
// ---------------------------------------------------------------
`define MSD_DROW0 4'h0
`define MSD_DROW1 4'h2
`define MSD_DROW2 4'h4
`define MSD_DROW3 4'h6
`define MSD_DROW4 4'h9
`define MSD_DROW5 4'hc
`define MSD_DROW6 4'hd
`define MSD_DROW7 4'he
`endif

// ==== msd_pkg.sv ====
// types for the microprogram store decode block
package msd_pkg;
   // bus handshake states, one-hot
   typedef enum logic [1:0] {
      MSD_BUS_IDLE = 2'h1,
      MSD_BUS_ACK = 2'h2
   } msd_bus_t;
endpackage

// ==== msd_store_decode.sv ====
// microprogram and decode store selection, readout and bus slave
//
// Overview of operation
// - low bit 07 picks side A or B
// - high bit 05 alone picks one board strobe
// - 00 basic board, bit 05 second board
// - one row and one column per access
// - amp strobe when either side select active
// - amplifiers pass only the selected side
// - strobe timing input gates side strobe
// - microword delivered on true and false rails
// - instr bits 0:3 row, 4:7 column
// - instr bits 4:7 one-hot of sixteen columns
// - eight decode rows, phase timing sets pulse
// - decode rows only with enable and phase
// - printed row codes, others select nothing
// - 8 by 16 decode matrix, one line
// - decode word returned single rail
// - each decode line gives twelve bits
// - row index from high 6, low 0:3
// - 32-bit line, strobe picks 16-bit half
`timescale 1ns/1ps
`include "msd_defs.svh"
module msd_store_decode
   import msd_pkg::*;
(
   input wire logic clk, // 200 MHz clock
   input wire logic nrst, // async reset, active low
   input wire logic [0:7] uaddrHigh, // high address byte
   input wire logic [0:7] uaddrLow, // low address byte
   input wire logic [0:7] instrWordReg, // instruction bits
   input wire logic phasePulseTiming, // row pulse phase
   input wire logic phasePulseTimingN, // decode phase, low
   input wire logic strobeTimingN, // strobe window, low
   input wire logic decodeReadEnableN, // decode read, low
   input wire logic [3:0] avAddress, // byte address
   input wire logic avRead, // read request
   input wire logic avWrite, // write request
   input wire logic [31:0] avWritedata, // write data
   output logic [31:0] avReaddata, // read data
   output logic avWaitrequest, // stall
   output logic [31:0] microRowSel, // x switches
   output logic [15:0] microColSel, // y switches
   output logic basicBoardSideAStrobe, // basic, side a
   output logic basicBoardSideBStrobe, // basic, side b
   output logic secondBoardSideAStrobe, // second, side a
   output logic secondBoardSideBStrobe, // second, side b
   output logic sideASelect, // side a readout
   output logic sideBSelect, // side b readout
   output logic ampStrobe, // amplifier strobe
   output logic [15:0] microwordTrue, // true rail
   output logic [15:0] microwordFalse, // false rail
   output logic [15:0] decodeColSel, // decode columns
   output logic [7:0] decodeRowSel, // decode rows
   output logic [11:0] decodeWord // decode readout
);
   // ---------------------------------------------------------------
   // decoding helpers
   // ---------------------------------------------------------------
   // one-hot of a five bit index, sliced for narrower selects
   function automatic logic [31:0] msd_onehot(input logic [4:0] n);
      msd_onehot = 32'h1 << n;
   endfunction

   // row code to row number; valid low when code is not printed
   function automatic logic [3:0] msd_drow(input logic [3:0] c);
      case (c)
         `MSD_DROW0: msd_drow = 4'h8;
         `MSD_DROW1: msd_drow = 4'h9;
         `MSD_DROW2: msd_drow = 4'ha;
         `MSD_DROW3: msd_drow = 4'hb;
         `MSD_DROW4: msd_drow = 4'hc;
         `MSD_DROW5: msd_drow = 4'hd;
         `MSD_DROW6: msd_drow = 4'he;
         `MSD_DROW7: msd_drow = 4'hf;
         default: msd_drow = 4'h0;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // store contents and software state
   // ---------------------------------------------------------------
   logic [31:0] microMem [0:1023]; // 2 boards x 512 lines
   logic [11:0] decodeMem [0:127]; // 8 x 16 lines
   logic [1:0] ctrl; // software enables
   logic [15:0] loadAddr; // load pointer
   msd_bus_t busState; // handshake state

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   logic [4:0] xIdx; // row switch number
   logic [3:0] yIdx; // column switch number
   logic board; // 0 basic, 1 second
   logic side; // 0 side a, 1 side b
   logic microOn; // row pulse window
   logic strobeOn; // strobe window
   logic [31:0] lineWord; // addressed word line
   logic [15:0] halfWord; // selected half
   logic [3:0] dRow; // decode row, bit 3 valid
   logic decodeOn; // decode window
   logic [11:0] next_decodeWord; // decode readout

   assign xIdx = {uaddrHigh[6], uaddrLow[0:3]};
   assign yIdx = {uaddrHigh[7], uaddrLow[4:6]};
   // bit 04 has no printed meaning alone; bit 05 alone picks board
   assign board = uaddrHigh[5];
   assign side = uaddrLow[7];
   assign microOn = phasePulseTiming && ctrl[`MSD_CTRL_UEN];
   assign strobeOn = microOn && !strobeTimingN;
   assign lineWord = microMem[{board, yIdx, xIdx}];
   // each amplifier sees both windings, the side select passes one
   assign halfWord = side ? lineWord[31:16] : lineWord[15:0];
   assign dRow = msd_drow(instrWordReg[0:3]);
   assign decodeOn = !decodeReadEnableN && !phasePulseTimingN
                     && ctrl[`MSD_CTRL_DEN];
   // an unprinted row code drives no line, so the sense reads zero
   assign next_decodeWord = dRow[3]
      ? decodeMem[{dRow[2:0], instrWordReg[4:7]}] : 12'h0;

   // ---------------------------------------------------------------
   // microprogram switch and strobe outputs
   // ---------------------------------------------------------------
   // selects follow the phase; all idle between pulses
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         microRowSel <= 32'h0;
         microColSel <= 16'h0;
      end else if (microOn) begin
         microRowSel <= msd_onehot(xIdx);
         microColSel <= 16'(msd_onehot({1'b0, yIdx}));
      end else begin
         microRowSel <= 32'h0;
         microColSel <= 16'h0;
      end
   end

   // board and side strobes, only inside the strobe window
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         basicBoardSideAStrobe <= 1'b0;
         basicBoardSideBStrobe <= 1'b0;
         secondBoardSideAStrobe <= 1'b0;
         secondBoardSideBStrobe <= 1'b0;
         sideASelect <= 1'b0;
         sideBSelect <= 1'b0;
         ampStrobe <= 1'b0;
      end else begin
         basicBoardSideAStrobe <= strobeOn && !board && !side;
         basicBoardSideBStrobe <= strobeOn && !board && side;
         secondBoardSideAStrobe <= strobeOn && board && !side;
         secondBoardSideBStrobe <= strobeOn && board && side;
         sideASelect <= strobeOn && !side;
         sideBSelect <= strobeOn && side;
         ampStrobe <= strobeOn;
      end
   end

   // readout register holds the last strobed word
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         microwordTrue <= 16'h0;
         microwordFalse <= 16'hffff;
      end else if (strobeOn) begin
         microwordTrue <= halfWord;
         microwordFalse <= ~halfWord;
      end
   end

   // ---------------------------------------------------------------
   // decode store outputs
   // ---------------------------------------------------------------
   // rows and columns only while enable and phase are both active
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         decodeRowSel <= 8'h0;
         decodeColSel <= 16'h0;
         decodeWord <= 12'h0;
      end else if (decodeOn) begin
         decodeRowSel <= dRow[3]
            ? 8'(msd_onehot({2'h0, dRow[2:0]})) : 8'h0;
         decodeColSel <= 16'(msd_onehot(
            {1'b0, instrWordReg[4:7]}));
         decodeWord <= next_decodeWord;
      end else begin
         decodeRowSel <= 8'h0;
         decodeColSel <= 16'h0;
      end
   end

   // ---------------------------------------------------------------
   // avalon slave, one wait state on every access
   // ---------------------------------------------------------------
   logic busReq; // request waiting for its answer
   logic busDone; // edge at which the access completes
   logic [31:0] next_readdata; // read mux

   assign busReq = (avRead || avWrite) && busState == MSD_BUS_IDLE;
   assign busDone = (avRead || avWrite) && busState == MSD_BUS_ACK;

   always_comb begin
      next_readdata = 32'h0; // unmapped reads as zero
      case (avAddress)
         `MSD_CTRL_OFS: next_readdata = {30'h0, ctrl};
         `MSD_LADDR_OFS: next_readdata = {16'h0, loadAddr};
         `MSD_STAT_OFS: next_readdata = {4'h0, decodeWord,
                                          microwordTrue};
         default: next_readdata = 32'h0;
      endcase
   end

   // handshake: waitrequest drops for exactly one cycle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busState <= MSD_BUS_IDLE;
         avWaitrequest <= 1'b1;
         avReaddata <= 32'h0;
      end else begin
         case (busState)
            MSD_BUS_IDLE: begin
               if (busReq) begin
                  busState <= MSD_BUS_ACK;
                  avWaitrequest <= 1'b0;
                  avReaddata <= next_readdata;
               end
            end
            MSD_BUS_ACK: begin
               busState <= MSD_BUS_IDLE;
               avWaitrequest <= 1'b1;
            end
            default: begin
               busState <= MSD_BUS_IDLE;
               avWaitrequest <= 1'b1;
            end
         endcase
      end
   end

   // control and load pointer; data writes step the pointer
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl <= `MSD_CTRL_RST;
         loadAddr <= 16'h0;
      end else if (busDone && avWrite) begin
         if (avAddress == `MSD_CTRL_OFS)
            ctrl <= avWritedata[1:0];
         if (avAddress == `MSD_LADDR_OFS)
            loadAddr <= avWritedata[15:0];
         if (avAddress == `MSD_LDATA_OFS)
            loadAddr <= loadAddr + 16'h1;
      end
   end

   // store loading; no reset, contents are software loaded
   always_ff @(posedge clk) begin
      if (busDone && avWrite && avAddress == `MSD_LDATA_OFS) begin
         if (loadAddr[`MSD_LADDR_DSEL])
            decodeMem[loadAddr[6:0]] <= avWritedata[11:0];
         else
            microMem[loadAddr[9:0]] <= avWritedata;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   sequence s_strobe;
      phasePulseTiming && ctrl[`MSD_CTRL_UEN] && !strobeTimingN;
   endsequence
   sequence s_idle;
      !phasePulseTiming;
   endsequence

   property p_side;
      @(posedge clk) disable iff (!nrst)
      s_strobe ##1 1'b1 |-> sideBSelect == $past(uaddrLow[7]);
   endproperty
   a_side: assert property (p_side) else $error("side wrong");

   property p_board;
      @(posedge clk) disable iff (!nrst)
      s_strobe |=> $onehot({basicBoardSideAStrobe,
         basicBoardSideBStrobe, secondBoardSideAStrobe,
         secondBoardSideBStrobe});
   endproperty
   a_board: assert property (p_board) else $error("board");

   property p_second;
      @(posedge clk) disable iff (!nrst)
      s_strobe ##0 uaddrHigh[5] |=> secondBoardSideAStrobe
         || secondBoardSideBStrobe;
   endproperty
   a_second: assert property (p_second) else $error("2nd");

   property p_rowcol;
      @(posedge clk) disable iff (!nrst)
      phasePulseTiming && ctrl[`MSD_CTRL_UEN] |=>
         $onehot(microRowSel) && $onehot(microColSel);
   endproperty
   a_rowcol: assert property (p_rowcol) else $error("row");

   property p_amp;
      @(posedge clk) disable iff (!nrst)
      ampStrobe == (sideASelect || sideBSelect);
   endproperty
   a_amp: assert property (p_amp) else $error("amp");

   property p_rail;
      @(posedge clk) disable iff (!nrst)
      s_strobe |=> microwordTrue == $past(halfWord)
         && microwordFalse == ~$past(halfWord);
   endproperty
   a_rail: assert property (p_rail) else $error("rail");

   property p_dcol;
      @(posedge clk) disable iff (!nrst)
      decodeOn |=> decodeColSel ==
         (16'h1 << $past(instrWordReg[4:7]));
   endproperty
   a_dcol: assert property (p_dcol) else $error("dcol");

   property p_denable;
      @(posedge clk) disable iff (!nrst)
      decodeReadEnableN |=> decodeRowSel == 8'h0;
   endproperty
   a_denable: assert property (p_denable) else $error("den");

   property p_dbad;
      @(posedge clk) disable iff (!nrst)
      decodeOn && instrWordReg[0:3] == 4'h1 |=> decodeRowSel == 8'h0;
   endproperty
   a_dbad: assert property (p_dbad) else $error("dbad");

   property p_idle;
      @(posedge clk) disable iff (!nrst)
      s_idle ##1 s_idle |-> microRowSel == 32'h0 && !ampStrobe;
   endproperty
   a_idle: assert property (p_idle) else $error("idle");

endmodule // msd_store_decode

// ==== msd_seq_model.sv ====
// processor side model: microsequencer address and timing drive
`timescale 1ns/1ps
module msd_seq_model (
   input wire logic clk, // processor clock
   output logic [0:7] uaddrHigh, // high address byte
   output logic [0:7] uaddrLow, // low address byte
   output logic [0:7] instrWordReg, // instruction bits
   output logic phasePulseTiming, // micro phase, high
   output logic phasePulseTimingN, // decode phase, low
   output logic strobeTimingN, // strobe window, low
   output logic decodeReadEnableN // decode read, low
);
   // ------------------------------------------------------------
   // idle: released address and instruction lines show the inverse of the last value, timing lines go inactive
   // ------------------------------------------------------------
   // a released bus never keeps the old value, so a stale
   // capture in the design cannot pass by luck
   task automatic drop();
      uaddrHigh <= ~uaddrHigh;
      uaddrLow <= ~uaddrLow;
      instrWordReg <= ~instrWordReg;
      phasePulseTiming <= 1'b0;
      phasePulseTimingN <= 1'b1;
      strobeTimingN <= 1'b1;
      decodeReadEnableN <= 1'b1;
   endtask
   initial begin
      uaddrHigh = 8'h00;
      uaddrLow = 8'h00;
      instrWordReg = 8'h00;
      phasePulseTiming = 1'b0;
      phasePulseTimingN = 1'b1;
      strobeTimingN = 1'b1;
      decodeReadEnableN = 1'b1;
   end
   // ------------------------------------------------------------
   // accesses: drive after an edge, outputs settle one edge on
   // ------------------------------------------------------------
   task automatic idle();
      @(posedge clk);
      drop();
      @(posedge clk);
      #1;
   endtask
   task automatic micro(input logic [7:0] h, l, input logic sn);
      @(posedge clk);
      uaddrHigh <= h;
      uaddrLow <= l;
      phasePulseTiming <= 1'b1;
      strobeTimingN <= sn;
      @(posedge clk);
      #1;
   endtask
   task automatic decode(input logic [7:0] ir, input logic en);
      @(posedge clk);
      instrWordReg <= ir;
      phasePulseTimingN <= 1'b0;
      decodeReadEnableN <= !en;
      @(posedge clk);
      #1;
   endtask
endmodule // msd_seq_model

// ==== msd_store_decode_test.sv ====
// self-checking bench for the microprogram store decode block
`timescale 1ns/1ps
module msd_store_decode_test;
   import msd_pkg::*;
   logic clk, nrst, avRead, avWrite, avWaitrequest; // bench nets
   logic [3:0] avAddress; // byte address
   logic [31:0] avWritedata, avReaddata, rd; // bus data
   logic [0:7] uaddrHigh, uaddrLow, instrWordReg; // model drive
   logic phasePulseTiming, phasePulseTimingN, strobeTimingN;
   logic decodeReadEnableN, sideASelect, sideBSelect, ampStrobe;
   logic [31:0] microRowSel; // x switches
   logic [15:0] microColSel, microwordTrue, microwordFalse;
   logic [15:0] decodeColSel; // decode columns
   logic [7:0] decodeRowSel; // decode rows
   logic [11:0] decodeWord; // decode readout
   logic bA, bB, sA, sB; // board strobes
   int bad_count = 0;
   int n_tests = 0;
   logic [3:0] rowCode [8] = '{4'h0, 4'h2, 4'h4, 4'h6,
      4'h9, 4'hc, 4'hd, 4'he}; // printed row codes
   msd_seq_model m (.clk(clk), .uaddrHigh(uaddrHigh),
      .uaddrLow(uaddrLow), .instrWordReg(instrWordReg),
      .phasePulseTiming(phasePulseTiming),
      .phasePulseTimingN(phasePulseTimingN),
      .strobeTimingN(strobeTimingN),
      .decodeReadEnableN(decodeReadEnableN));
   msd_store_decode dut_u (.clk(clk), .nrst(nrst),
      .uaddrHigh(uaddrHigh), .uaddrLow(uaddrLow),
      .instrWordReg(instrWordReg),
      .phasePulseTiming(phasePulseTiming),
      .phasePulseTimingN(phasePulseTimingN),
      .strobeTimingN(strobeTimingN),
      .decodeReadEnableN(decodeReadEnableN),
      .avAddress(avAddress), .avRead(avRead), .avWrite(avWrite),
      .avWritedata(avWritedata), .avReaddata(avReaddata),
      .avWaitrequest(avWaitrequest), .microRowSel(microRowSel),
      .microColSel(microColSel), .basicBoardSideAStrobe(bA),
      .basicBoardSideBStrobe(bB), .secondBoardSideAStrobe(sA),
      .secondBoardSideBStrobe(sB), .sideASelect(sideASelect),
      .sideBSelect(sideBSelect), .ampStrobe(ampStrobe),
      .microwordTrue(microwordTrue),
      .microwordFalse(microwordFalse),
      .decodeColSel(decodeColSel), .decodeRowSel(decodeRowSel),
      .decodeWord(decodeWord));
   // ------------------------------------------------------------
   // clock, report and compare helpers
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t saw %h wanted %h", $time, got, exp);
      end
   endtask
   // one access: hold until waitrequest is sampled low, bounded
   task automatic bus(input logic wr, input logic [3:0] a,
      input logic [31:0] d);
      int k;
      @(posedge clk);
      avAddress <= a;
      avWritedata <= d;
      avRead <= !wr;
      avWrite <= wr;
      for (k = 0; k < 20; k++) begin
         @(posedge clk);
         if (avWaitrequest === 1'b0) break;
      end
      rd = avReaddata;
      avRead <= 1'b0;
      avWrite <= 1'b0;
      if (k == 20) begin
         bad_count++;
         $display("ERROR %0t bus stuck", $time);
         close_out();
      end
   endtask
   // ------------------------------------------------------------
   // microprogram line: load, read both halves, window off, idle
   // ------------------------------------------------------------
   task automatic line(input logic b, input logic [4:0] x,
      input logic [3:0] y, input logic [31:0] d);
      logic [15:0] hw;
      bus(1'b1, 4'h4, {22'h0, b, y, x});
      bus(1'b1, 4'h8, d);
      for (int s = 0; s < 2; s++) begin
         hw = s ? d[31:16] : d[15:0];
         m.micro({5'h0, b, x[4], y[3]}, {x[3:0], y[2:0], s[0]}, 0);
         chk(microRowSel, 32'h1 << x);
         chk(microColSel, 16'h1 << y);
         chk({bA, bB, sA, sB}, 4'h8 >> {b, s[0]});
         chk({sideASelect, sideBSelect, ampStrobe},
            {!s[0], s[0], 1'b1});
         chk(microwordTrue, hw);
         chk(microwordFalse, 16'(~hw));
         bus(1'b0, 4'hc, 0);
         chk(rd[15:0], hw);
         m.micro({5'h0, b, x[4], y[3]}, {x[3:0], y[2:0], !s[0]}, 1);
         chk({bA, bB, sA, sB, ampStrobe}, 0);
         chk(microwordTrue, hw);
         m.idle();
         chk(microRowSel, 0);
         chk({microColSel, bA, bB, sA, sB}, 0);
      end
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      nrst = 1'b0;
      avRead = 1'b0;
      avWrite = 1'b0;
      avAddress = 4'h0;
      avWritedata = 32'h0;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      #1;
      chk({avWaitrequest, microwordFalse, decodeWord}, 29'h1ffff000);
      bus(1'b0, 4'h0, 0);
      chk(rd, 32'h3);
      bus(1'b0, 4'h2, 0);
      chk(rd, 32'h0);
      $display("test reset and map done");
      line(1'b0, 5'h05, 4'h9, 32'h5a3c_c3a5);
      line(1'b1, 5'h1f, 4'h0, 32'h0ff0_8001);
      bus(1'b1, 4'h0, 32'h2);
      m.micro(8'h04, 8'h31, 0);
      chk(microRowSel, 0);
      chk({microColSel, bA, bB, sA, sB, ampStrobe}, 0);
      m.idle();
      bus(1'b1, 4'h0, 32'h3);
      $display("test micro store done");
      bus(1'b1, 4'h4, 32'h8000);
      for (int i = 0; i < 128; i++) bus(1'b1, 4'h8, i * 13 + 5);
      for (int i = 0; i < 16; i++) begin
         m.decode({rowCode[i % 8], i[3:0]}, 1);
         chk(decodeRowSel, 8'h1 << (i % 8));
         chk(decodeColSel, 16'h1 << i);
         chk(decodeWord, ((i % 8) * 16 + i) * 13 + 5);
         bus(1'b0, 4'hc, 0);
         chk(rd[27:16], ((i % 8) * 16 + i) * 13 + 5);
      end
      m.decode(8'h17, 1);
      chk({decodeRowSel, decodeWord}, 0);
      m.decode(8'h23, 0);
      chk({decodeRowSel, decodeColSel}, 0);
      m.idle();
      chk({decodeRowSel, decodeColSel}, 0);
      $display("test decode store done");
      close_out();
   end
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      $display("ERROR %0t run too long", $time);
      close_out();
   end
endmodule // msd_store_decode_test
